/* File: inc/amr_pkg.sv */
// Package: constants and types for the accumulator move, return and rotate decoder
// Behaviour
// - Store accumulator into selected file register, flags kept
// - Return word loads accumulator with low byte
// - Return pops stack top into program counter
// - Return takes two cycles, prefetch discarded
// - Rotate left through carry, carry is the only flag that changes
// - Destination bit picks accumulator or file register
package amr_pkg;

	localparam int WORD_W = 12;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam int PC_W   = 9;

	// Opcode patterns
	localparam logic [6:0]  OP_STORE_HI  = 7'h01;   // 0000 001f ffff, bits 11:5
	localparam logic [3:0]  OP_RETURN_HI = 4'h8;    // 1000 kkkk kkkk, bits 11:8
	localparam logic [5:0]  OP_ROTATE_HI = 6'h0D;   // 0011 01df ffff, bits 11:6
	localparam logic [11:0] OP_IDLE      = 12'h000;
	localparam logic [11:0] OP_OPTION    = 12'h002;

	// Field positions
	localparam int DEST_BIT  = 5;
	localparam int CARRY_BIT = 0;

	// Reset values
	localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
	localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} amr_file_wr_t;

	typedef struct packed {
		logic            load;
		logic [PC_W-1:0] target;
	} amr_pc_load_t;

	typedef enum logic [0:0] {
		ST_EXEC  = 1'b0,
		ST_FLUSH = 1'b1
	} amr_state_t;

endpackage

/* File: rtl/amr_decoder.sv */
// Module: decode and execute of store, idle, option, return and rotate words
`timescale 1ns/100ps
module amr_decoder (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          instr_valid,
	input  wire logic [amr_pkg::WORD_W-1:0]    instr,
	input  wire logic [amr_pkg::DATA_W-1:0]    file_rd_data,
	input  wire logic [amr_pkg::PC_W-1:0]      stack_top_entry,
	input  wire logic                          carry_in,
	output amr_pkg::amr_file_wr_t              file_wr,
	output logic      [amr_pkg::ADDR_W-1:0]    file_rd_addr,
	output logic      [amr_pkg::DATA_W-1:0]    accumulator,
	output logic      [amr_pkg::DATA_W-1:0]    option_reg,
	output logic                               carry_wr,
	output logic                               carry_out,
	output amr_pkg::amr_pc_load_t              pc_load,
	output logic                               stack_pop,
	output logic                               flush,
	output logic                               busy
);
	import amr_pkg::*;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	amr_state_t state;
	amr_state_t next_state;
	logic       is_store;
	logic       is_return;
	logic       is_rotate;
	logic       is_option;
	logic       take;
	logic [DATA_W-1:0] rotated;

	assign take      = instr_valid && (state == ST_EXEC);
	assign is_store  = take && (instr[11:5] == OP_STORE_HI);
	assign is_return = take && (instr[11:8] == OP_RETURN_HI);
	assign is_rotate = take && (instr[11:6] == OP_ROTATE_HI);
	assign is_option = take && (instr == OP_OPTION);
	// Operand read address follows the word in flight
	assign rotated   = {file_rd_data[DATA_W-2:0], carry_in};

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	amr_file_wr_t      next_file_wr;
	logic [ADDR_W-1:0] next_file_rd_addr;
	logic [DATA_W-1:0] next_accumulator;
	logic [DATA_W-1:0] next_option_reg;
	logic              next_carry_wr;
	logic              next_carry_out;
	amr_pc_load_t      next_pc_load;
	logic              next_stack_pop;
	logic              next_flush;
	logic              next_busy;

	always_comb begin
		next_state        = ST_EXEC;
		next_file_wr      = '0;
		next_file_rd_addr = instr[ADDR_W-1:0];
		next_accumulator  = accumulator;
		next_option_reg   = option_reg;
		next_carry_wr     = 1'b0;
		next_carry_out    = carry_out;
		next_pc_load      = '0;
		next_stack_pop    = 1'b0;
		next_flush        = 1'b0;
		next_busy         = 1'b0;
		unique case (state)
			ST_EXEC: begin
				if (is_store) begin
					next_file_wr.en   = 1'b1;
					next_file_wr.addr = instr[ADDR_W-1:0];
					next_file_wr.data = accumulator;
				end
				if (is_return) begin
					next_accumulator    = instr[DATA_W-1:0];
					next_pc_load.load   = 1'b1;
					next_pc_load.target = stack_top_entry;
					next_stack_pop      = 1'b1;
					next_flush          = 1'b1;
					next_busy           = 1'b1;
					next_state          = ST_FLUSH;
				end
				if (is_rotate) begin
					next_carry_wr  = 1'b1;
					next_carry_out = file_rd_data[DATA_W-1];
					if (instr[DEST_BIT]) begin
						next_file_wr.en   = 1'b1;
						next_file_wr.addr = instr[ADDR_W-1:0];
						next_file_wr.data = rotated;
					end else begin
						next_accumulator = rotated;
					end
				end
				if (is_option) begin
					next_option_reg = accumulator;
				end
			end
			ST_FLUSH: begin
				// Prefetched word is dropped; execution resumes next cycle
				next_state = ST_EXEC;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state        <= ST_EXEC;
			file_wr      <= '0;
			file_rd_addr <= '0;
			accumulator  <= ACC_RST;
			option_reg   <= OPTION_RST;
			carry_wr     <= 1'b0;
			carry_out    <= 1'b0;
			pc_load      <= '0;
			stack_pop    <= 1'b0;
			flush        <= 1'b0;
			busy         <= 1'b0;
		end else begin
			state        <= next_state;
			file_wr      <= next_file_wr;
			file_rd_addr <= next_file_rd_addr;
			accumulator  <= next_accumulator;
			option_reg   <= next_option_reg;
			carry_wr     <= next_carry_wr;
			carry_out    <= next_carry_out;
			pc_load      <= next_pc_load;
			stack_pop    <= next_stack_pop;
			flush        <= next_flush;
			busy         <= next_busy;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_return_taken;
		is_return;
	endsequence

	sequence s_flush_cycle;
		flush && pc_load.load && stack_pop ##1 (state == ST_EXEC) && !flush;
	endsequence

	a_store_write: assert property (@(posedge clk) disable iff (rst)
		is_store |=> file_wr.en && file_wr.data == $past(accumulator) && !carry_wr)
		else $error("store did not write accumulator");
	a_return_acc: assert property (@(posedge clk) disable iff (rst)
		is_return |=> accumulator == $past(instr[7:0]) && !carry_wr)
		else $error("return did not load immediate");
	a_return_pc: assert property (@(posedge clk) disable iff (rst)
		is_return |=> pc_load.target == $past(stack_top_entry))
		else $error("return did not load stack top");
	a_return_two: assert property (@(posedge clk) disable iff (rst)
		s_return_taken |=> s_flush_cycle)
		else $error("return not two cycles");
	a_flush_blocks: assert property (@(posedge clk) disable iff (rst)
		state == ST_FLUSH |=> !file_wr.en && !carry_wr && !pc_load.load
			&& $stable(accumulator) && $stable(option_reg))
		else $error("word taken during flush");
	a_rotate_carry: assert property (@(posedge clk) disable iff (rst)
		is_rotate |=> carry_wr && carry_out == $past(file_rd_data[7]))
		else $error("rotate carry wrong");
	a_rotate_dest: assert property (@(posedge clk) disable iff (rst)
		is_rotate && !instr[5] |=> !file_wr.en
			&& accumulator == {$past(file_rd_data[6:0]), $past(carry_in)})
		else $error("rotate to accumulator wrong");
	a_rotate_file: assert property (@(posedge clk) disable iff (rst)
		is_rotate && instr[5] |=> file_wr.en && $stable(accumulator)
			&& file_wr.addr == $past(instr[ADDR_W-1:0])
			&& file_wr.data == {$past(file_rd_data[6:0]), $past(carry_in)})
		else $error("rotate to file wrong");
	a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
		take && instr == OP_IDLE |=> !file_wr.en && !carry_wr && $stable(accumulator))
		else $error("idle word changed state");
	a_option_load: assert property (@(posedge clk) disable iff (rst)
		is_option |=> option_reg == $past(accumulator))
		else $error("option not loaded");

	// ----------------------------------------
	// Side effects
	// ----------------------------------------
	a_store_addr: assert property (@(posedge clk) disable iff (rst)
		is_store |=> file_wr.addr == $past(instr[ADDR_W-1:0]))
		else $error("store wrote wrong register");
	a_store_quiet: assert property (@(posedge clk) disable iff (rst)
		is_store |=> $stable(accumulator) && $stable(option_reg) && !pc_load.load && !stack_pop)
		else $error("store touched other state");
	a_return_quiet: assert property (@(posedge clk) disable iff (rst)
		is_return |=> !file_wr.en && $stable(option_reg) && $stable(carry_out))
		else $error("return touched other state");
	a_pop_once: assert property (@(posedge clk) disable iff (rst)
		pc_load.load |=> !pc_load.load && !stack_pop)
		else $error("stack popped twice");
	a_pop_source: assert property (@(posedge clk) disable iff (rst)
		!is_return |=> !pc_load.load && !stack_pop && !flush)
		else $error("pop without return");
	a_flush_busy: assert property (@(posedge clk) disable iff (rst)
		flush |-> busy && stack_pop)
		else $error("flush without busy");
	a_rotate_only: assert property (@(posedge clk) disable iff (rst)
		is_rotate |=> $stable(option_reg) && !pc_load.load && !stack_pop)
		else $error("rotate touched other state");
	a_carry_hold: assert property (@(posedge clk) disable iff (rst)
		!is_rotate |=> !carry_wr && $stable(carry_out))
		else $error("carry changed without rotate");
	a_write_source: assert property (@(posedge clk) disable iff (rst)
		!is_store && !is_rotate |=> !file_wr.en)
		else $error("file write without store or rotate");
	a_option_quiet: assert property (@(posedge clk) disable iff (rst)
		is_option |=> !file_wr.en && !carry_wr && !pc_load.load && $stable(accumulator))
		else $error("option touched other state");
	a_option_hold: assert property (@(posedge clk) disable iff (rst)
		!is_option |=> $stable(option_reg))
		else $error("option changed without option word");
	a_unknown_quiet: assert property (@(posedge clk) disable iff (rst)
		take && !is_store && !is_return && !is_rotate && !is_option
			|=> !file_wr.en && !carry_wr && !pc_load.load && !stack_pop
			&& $stable(accumulator) && $stable(option_reg))
		else $error("unknown word changed state");

endmodule

/* File: tb/tb.sv */
// Testbench: directed checks of the accumulator move, return and rotate decoder
`timescale 1ns/100ps
module tb;
	import amr_pkg::*;
	logic              clk;
	logic              rst;
	logic              instr_valid;
	logic [WORD_W-1:0] instr;
	logic [DATA_W-1:0] file_rd_data;
	logic [PC_W-1:0]   stack_top_entry;
	logic              carry_in;
	amr_file_wr_t      file_wr;
	logic [ADDR_W-1:0] file_rd_addr;
	logic [DATA_W-1:0] accumulator;
	logic [DATA_W-1:0] option_reg;
	logic              carry_wr;
	logic              carry_out;
	amr_pc_load_t      pc_load;
	logic              stack_pop;
	logic              flush;
	logic              busy;
	int                n_errors;
	int                checks_done;

	amr_decoder i_amr_decoder (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
		.file_rd_data(file_rd_data), .stack_top_entry(stack_top_entry), .carry_in(carry_in),
		.file_wr(file_wr), .file_rd_addr(file_rd_addr), .accumulator(accumulator),
		.option_reg(option_reg),
		.carry_wr(carry_wr), .carry_out(carry_out), .pc_load(pc_load), .stack_pop(stack_pop),
		.flush(flush), .busy(busy));

	always #2 clk = ~clk;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Present one word; return when its results stand
	task automatic put(input logic [11:0] w, input logic [7:0] fd, input logic ci, input logic hold);
		@(posedge clk);
		#1;
		instr = w;
		file_rd_data = fd;
		carry_in = ci;
		instr_valid = 1'b1;
		@(posedge clk);
		#1;
		if (!hold) begin
			instr_valid = 1'b0;
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_return;
		stack_top_entry = 9'h1C3;
		put(12'h8A5, 8'h00, 1'b0, 1'b1);
		chk(16'(accumulator), 16'h00A5, "return acc");
		chk(16'(pc_load), 16'(10'h3C3), "return pc");
		chk(16'({stack_pop, flush, busy}), 16'h0007, "return pop");
		instr = 12'h03F;
		@(posedge clk);
		#1;
		instr_valid = 1'b0;
		chk(16'({file_wr.en, busy, pc_load.load}), 16'h0000, "prefetch");
	endtask

	task automatic t_store;
		put(12'h03F, 8'h00, 1'b0, 1'b0);
		chk(16'(file_wr), 16'(14'h3FA5), "store");
		chk(16'(carry_wr), 16'h0000, "store flag");
		chk(16'(file_rd_addr), 16'h001F, "store rd addr");
	endtask

	task automatic t_idle_option;
		put(12'h000, 8'h00, 1'b0, 1'b0);
		chk({option_reg, accumulator}, 16'hFFA5, "idle");
		chk(16'({file_wr.en, carry_wr}), 16'h0000, "idle wr");
		put(12'h002, 8'h00, 1'b0, 1'b0);
		chk(16'(option_reg), 16'h00A5, "option");
		put(12'h003, 8'h00, 1'b0, 1'b0);
		chk({option_reg, accumulator}, 16'hA5A5, "unknown");
		chk(16'({file_wr.en, carry_wr, pc_load.load, stack_pop}), 16'h0000, "unknown wr");
	endtask

	task automatic t_rotate;
		put(12'h345, 8'hE6, 1'b0, 1'b0);
		chk(16'(accumulator), 16'h00CC, "rot acc");
		chk(16'({carry_wr, carry_out, file_wr.en}), 16'h0006, "rot c");
		put(12'h36A, 8'h5A, 1'b1, 1'b0);
		chk(16'(file_wr), 16'(14'h2AB5), "rot file");
		chk({6'h00, carry_wr, carry_out, accumulator}, 16'h02CC, "rot c2");
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = 12'h000;
		file_rd_data = 8'h00;
		stack_top_entry = 9'h000;
		carry_in = 1'b0;
		n_errors = 0;
		checks_done = 0;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		chk({option_reg, accumulator}, 16'hFF00, "reset");
		t_return();
		t_store();
		t_idle_option();
		t_rotate();
		tally_and_finish();
	end
endmodule
